// >>> hdl/pci_unit.sv
// Purpose: pin change interrupt unit for three ports
// Assumes: software side as plain write strobes, one port per write
// Notes:   clock must run during sleep for wake detection
`timescale 1ns/100ps
`include "pci_cfg.svh"
module pci_unit (
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic [`PCI_PORT_W-1:0] port_pins,
   input  wire logic                   change_irq_master_enable,
   input  wire logic                   sleep_mode,
   input  pci_pkg::pci_port_e          wr_port,
   input  wire logic                   wr_rise,
   input  wire logic                   wr_fall,
   input  wire logic                   wr_flag,
   input  pci_pkg::pci_byte_t          wr_data,
   output logic [`PCI_PORT_W-1:0]      rise_detect_enable_reg,
   output logic [`PCI_PORT_W-1:0]      fall_detect_enable_reg,
   output logic [`PCI_PORT_W-1:0]      pin_change_flag_reg,
   output logic                        change_irq_summary_flag,
   output logic                        irq_req,
   output logic                        wake_req
);
   import pci_pkg::*;
   localparam logic [`PCI_PORT_W-1:0] IMPL_MASK = {`PCI_THIRD_PORT_MASK,
                                                   `PCI_SECOND_PORT_MASK,
                                                   `PCI_FIRST_PORT_MASK};
   logic [`PCI_PORT_W-1:0] hit;
   logic [`PCI_PORT_W-1:0] sel;
   logic [`PCI_PORT_W-1:0] wdata;
   logic [`PCI_PORT_W-1:0] next_rise;
   logic [`PCI_PORT_W-1:0] next_fall;
   logic [`PCI_PORT_W-1:0] next_flag;
   logic                   next_summary;
   logic                   next_irq;
   logic                   next_wake;

   // Every pin gets a detector; unimplemented ones are masked by enables
   genvar gi;
   generate
      for (gi = 0; gi < `PCI_PORT_W; gi++) begin : g_pin
         pci_edge_det u_det (
            .core_clk (core_clk),
            .rst      (rst),
            .pin      (port_pins[gi]),
            .rise_en  (rise_detect_enable_reg[gi]),
            .fall_en  (fall_detect_enable_reg[gi]),
            .edge_hit (hit[gi])
         );
      end
   endgenerate

   always_comb begin
      sel = '0;
      if (wr_port == PCI_PORT_A) begin
         sel[7:0] = 8'hFF;
      end else if (wr_port == PCI_PORT_B) begin
         sel[15:8] = 8'hFF;
      end else if (wr_port == PCI_PORT_C) begin
         sel[23:16] = 8'hFF;
      end
      sel   = sel & IMPL_MASK;
      wdata = {wr_data, wr_data, wr_data};
      next_rise = rise_detect_enable_reg;
      next_fall = fall_detect_enable_reg;
      next_flag = pin_change_flag_reg;
      if (wr_rise) begin
         next_rise = (rise_detect_enable_reg & ~sel) | (wdata & sel);
      end
      if (wr_fall) begin
         next_fall = (fall_detect_enable_reg & ~sel) | (wdata & sel);
      end
      // Written zero clears; written one keeps, software cannot set a flag
      if (wr_flag) begin
         next_flag = pin_change_flag_reg & (wdata | ~sel);
      end
      // Edge in the same cycle wins over the write
      next_flag = (next_flag | hit) & IMPL_MASK;
      next_summary = |next_flag;
      next_irq  = next_summary & change_irq_master_enable;
      next_wake = next_irq & sleep_mode;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rise_detect_enable_reg  <= '0;
         fall_detect_enable_reg  <= '0;
         pin_change_flag_reg     <= '0;
         change_irq_summary_flag <= 1'b0;
         irq_req                 <= 1'b0;
         wake_req                <= 1'b0;
      end else begin
         rise_detect_enable_reg  <= next_rise;
         fall_detect_enable_reg  <= next_fall;
         pin_change_flag_reg     <= next_flag;
         change_irq_summary_flag <= next_summary;
         irq_req                 <= next_irq;
         wake_req                <= next_wake;
      end
   end
endmodule

// >>> hdl/pci_cfg.svh
// Purpose: constants for the pin change interrupt unit
// Assumes: one 8-bit register per port, software access by plain ports
// Notes:   first port has six pins, bits 7-6 read as zero
// Functional notes
// - Every pin can be source except first port bits 7-6 and second port bits 3-0
// - Master enable needed before any interrupt
// - Master off: flags still set, no interrupt
// - Each pin has rising and falling detector
// - Rising detect only when rise enable set
// - Falling detect only when fall enable set
// - Both enables set: either polarity detected
// - Enabled edge sets sticky per-pin flag
// - Interrupt request when flag set and enabled
// - Summary flag is OR of all flags
// - Writing zero clears a flag bit
// - Edge during clearing write leaves flag set
// - Hardware edge beats written data either way
// - First port: six bits, top two read zero
// - Change in sleep wakes device if enabled
// - Sleep edge recorded before first instruction
`ifndef PCI_CFG_SVH
`define PCI_CFG_SVH
`define PCI_REG_W        8
`define PCI_NUM_PORTS    3
`define PCI_PORT_W       24
`define PCI_FIRST_PORT_MASK  8'h3F
`define PCI_SECOND_PORT_MASK 8'hF0
`define PCI_THIRD_PORT_MASK  8'hFF
`define PCI_REG_RESET    8'h00
`define PCI_SYNC_STAGES  2
`endif

// >>> hdl/pci_pkg.sv
// Purpose: types for the pin change interrupt unit
// Assumes: three 8-bit ports
// Notes:   port select codes for software writes
package pci_pkg;
   typedef logic [7:0] pci_byte_t;
   typedef enum logic [1:0] {
      PCI_PORT_A = 2'b00,
      PCI_PORT_B = 2'b01,
      PCI_PORT_C = 2'b10,
      PCI_PORT_NONE = 2'b11
   } pci_port_e;
endpackage

// >>> hdl/pci_edge_det.sv
// Purpose: synchroniser and edge detector for one pin
// Assumes: pin asynchronous to core_clk in real use
// Notes:   edge pulses last one cycle
`timescale 1ns/100ps
`include "pci_cfg.svh"
module pci_edge_det (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic rise_en,
   input  wire logic fall_en,
   output logic      edge_hit
);
   import pci_pkg::*;
   logic meta;
   logic sync;
   logic prev;
   logic next_hit;
   // First stage read only by the second
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end
   // Two detectors, either or both enabled
   always_comb begin
      next_hit = (rise_en & sync & ~prev) | (fall_en & ~sync & prev);
   end
   assign edge_hit = next_hit;
endmodule

// >>> verification/pci_unit_properties.sv
// Purpose: port assertions for pci_unit
// Assumes: one clock domain, async reset
// Notes:   pins 0 and 1 stand for all pins
`timescale 1ns/100ps
module pci_unit_chk (
   input wire logic          core_clk,
   input wire logic          rst,
   input wire logic [23:0]   port_pins,
   input wire logic          change_irq_master_enable,
   input wire logic          sleep_mode,
   input wire logic          wr_flag,
   input wire logic [23:0]   rise_detect_enable_reg,
   input wire logic [23:0]   fall_detect_enable_reg,
   input wire logic [23:0]   pin_change_flag_reg,
   input wire logic          change_irq_summary_flag,
   input wire logic          irq_req,
   input wire logic          wake_req
);
   import pci_pkg::*;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_sum; change_irq_summary_flag == |pin_change_flag_reg; endproperty
   a_sum: assert property (p_sum) else $error("summary");
   property p_off; !change_irq_master_enable [*2] |-> !irq_req; endproperty
   a_off: assert property (p_off) else $error("irq off");
   property p_on; (change_irq_master_enable && change_irq_summary_flag) [*2] |-> irq_req; endproperty
   a_on: assert property (p_on) else $error("irq on");
   // Wake follows the request, gated by sleep one cycle earlier
   property p_wake; wake_req == (irq_req && $past(sleep_mode)); endproperty
   a_wake: assert property (p_wake) else $error("wake");
   // Flags fall only after a clearing write
   property p_stick;
      !$past(wr_flag) |-> (pin_change_flag_reg & $past(pin_change_flag_reg)) == $past(pin_change_flag_reg);
   endproperty
   a_stick: assert property (p_stick) else $error("sticky");
   property p_map;
      ((rise_detect_enable_reg | fall_detect_enable_reg | pin_change_flag_reg) & 24'h000FC0) == 24'h000000;
   endproperty
   a_map: assert property (p_map) else $error("unused bits");
   property p_rise; rise_detect_enable_reg[0] && $rose(port_pins[0]) |-> ##3 pin_change_flag_reg[0]; endproperty
   a_rise: assert property (p_rise) else $error("rise");
   property p_fall; fall_detect_enable_reg[1] && $fell(port_pins[1]) |-> ##3 pin_change_flag_reg[1]; endproperty
   a_fall: assert property (p_fall) else $error("fall");
   c_wake: cover property (wake_req);
   c_irq: cover property (irq_req);
   c_flag: cover property (change_irq_summary_flag);
endmodule
bind pci_unit pci_unit_chk chk (.core_clk, .rst, .port_pins, .change_irq_master_enable, .sleep_mode, .wr_flag,
   .rise_detect_enable_reg,
   .fall_detect_enable_reg, .pin_change_flag_reg, .change_irq_summary_flag, .irq_req, .wake_req);

// >>> verification/pci_pin_src.sv
// Purpose: outside world on the port pins
// Assumes: levels move only when told
// Notes:   no bounce, so edges are clean
`timescale 1ns/100ps
module pci_pin_src (
   output logic [23:0] port_pins
);
   initial port_pins = 24'h000000;
   task put(input logic [23:0] v);
      port_pins = v;
   endtask
endmodule

// >>> verification/testbench.sv
// Purpose: directed test of pci_unit
// Assumes: inputs move 1 ns after the edge
// Notes:   flags land on the third edge after a pin move
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
   import pci_pkg::*;
   logic        core_clk = 0, rst = 1, en = 0, slp = 0, w_r = 0, w_f = 0, w_c = 0, sum, irq, wk;
   pci_port_e   wp = PCI_PORT_NONE;
   pci_byte_t   wd = 8'h00;
   logic [23:0] pins, re, fe, fl;
   int          n_fail = 0, checks = 0, cyc = 0;
   always #25 core_clk = ~core_clk;
   pci_pin_src drv (.port_pins(pins));
   pci_unit dut (.core_clk, .rst, .port_pins(pins), .change_irq_master_enable(en), .sleep_mode(slp), .wr_port(wp),
      .wr_rise(w_r), .wr_fall(w_f), .wr_flag(w_c), .wr_data(wd), .rise_detect_enable_reg(re),
      .fall_detect_enable_reg(fe), .pin_change_flag_reg(fl), .change_irq_summary_flag(sum), .irq_req(irq), .wake_req(wk));
   task stop_test;
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task go(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Strobe dropped a cycle before return, so calls never collide
   task wr(input pci_port_e p, input logic [2:0] k, input pci_byte_t d);
      {w_r, w_f, w_c, wd} = {k, d};
      wp = p;
      go(1);
      {w_r, w_f, w_c} = 3'b000;
      go(1);
   endtask
   always @(posedge core_clk) if (++cyc > 500) begin n_fail++; stop_test; end
   initial begin
      go(2);
      rst = 0;
      `CHK("rst", 75'h0, {re, fe, fl, sum, irq, wk})
      wr(PCI_PORT_A, 3'b100, 8'h05);
      wr(PCI_PORT_A, 3'b010, 8'hC6);
      wr(PCI_PORT_B, 3'b110, 8'hFF);
      wr(PCI_PORT_C, 3'b110, 8'hFF);
      wr(PCI_PORT_NONE, 3'b110, 8'h00);
      `CHK("rise", 24'hFFF005, re)
      `CHK("fall", 24'hFFF006, fe)
      drv.put(24'h00000F);
      go(4);
      `CHK("up", 26'h000016, {fl, sum, irq})
      wr(PCI_PORT_A, 3'b001, ~fl[7:0]);
      `CHK("clr", 25'h0, {fl, sum})
      drv.put(24'h000000);
      go(4);
      `CHK("down", 24'h000006, fl)
      wr(PCI_PORT_A, 3'b001, 8'h00);
      en = 1;
      slp = 1;
      drv.put(24'hFF0000);
      go(5);
      `CHK("wake", 27'h7F80007, {fl, sum, irq, wk})
      slp = 0;
      drv.put(24'hFE0000);
      // Clear strobe must meet the fall on the same edge
      go(2);
      wr(PCI_PORT_C, 3'b001, 8'h00);
      `CHK("race", 26'h0040002, {fl, irq, wk})
      rst = 1;
      go(1);
      rst = 0;
      `CHK("rst2", 75'h0, {re, fe, fl, sum, irq, wk})
      stop_test;
   end
endmodule
